// >>> inc/rsc_defs.vh
// rsc_defs.vh: constants of the chip reset sequencer
// assumes the includer counts everything in reference clock cycles
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH

// sequencer states
`define RSC_ST_IDLE 3'h0
`define RSC_ST_POR 3'h1
`define RSC_ST_HARD 3'h2
`define RSC_ST_TAIL 3'h3
`define RSC_ST_SOFT 3'h4
`define RSC_ST_QUIET 3'h5

// reset classes
`define RSC_CLS_POR 2'h0
`define RSC_CLS_HARD 2'h1
`define RSC_CLS_SOFT 2'h2
`define RSC_CLS_NONE 2'h3

// configuration source select encodings
`define RSC_SRC_PINS 3'h0
`define RSC_SRC_I2C 3'h1

// input clock range pin codes: bit 1 set means 66 MHz or more
`define RSC_RNG_33_44 2'h0
`define RSC_RNG_44_66 2'h1
`define RSC_RNG_66_100 2'h2
`define RSC_RNG_100_133 2'h3

// hard reset release after power-on release, in reference cycles
`define RSC_PINS_LO_CYC 18'd15369
`define RSC_PINS_HI_CYC 18'd34825
`define RSC_I2C_B0_CYC 18'd92545
`define RSC_I2C_B1_CYC 18'd107435
`define RSC_I2C_B2_CYC 18'd124208
`define RSC_I2C_B3_CYC 18'd157880

// soft release after hard release
`define RSC_TAIL_CYC 18'd16
// soft-only sequence length
`define RSC_SOFT_HOLD_CYC 18'd16
// settling time after line release while the synchronisers catch up
`define RSC_QUIET_CYC 18'd4

`define RSC_CNT_W 18
`define RSC_WORD_W 17
`define RSC_SYNC_W 26

`endif

// >>> verilog/rsc_sync.v
// rsc_sync.v: two-stage synchroniser for a bundle of asynchronous pins
// assumes each bit is independent; multi-bit fields must be stable while sampled
`timescale 1ns/1ps
module rsc_sync #(
    parameter WIDTH = 1
) (
    input wire clk_i,
    input wire reset_i,
    input wire [WIDTH-1:0] d_i,
    output wire [WIDTH-1:0] q_o
);
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            reg meta_r;
            reg sync_r;
            always @(posedge clk_i or posedge reset_i) begin
                if (reset_i) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                end else begin
                    meta_r <= d_i[g];
                    sync_r <= meta_r;
                end
            end
            assign q_o[g] = sync_r;
        end
    endgenerate
endmodule // rsc_sync

// >>> verilog/rsc_top.v
// rsc_top.v: chip reset sequencer with power-on configuration sampling
// assumes clk_i is the reference clock; pins are asynchronous, internal requests are on clk_i
`timescale 1ns/1ps
`include "rsc_defs.vh"

// What this block does
// - configuration sampled and PLL reset on power-on only
// - every class resets peripheral bus and cores
// - full resets on power-on/hard, partial on soft
// - soft drives soft line only; hard drives both
// - sample source select and word pins
// - config word from I2C, pins or constant
// - boot stop pin sampled for I2C loading
// - pins/constant source: hard release 15369/34825 cycles
// - I2C source: power-on hard release by four clock bands
// - soft release 16 cycles after hard release
// - soft line held whenever hard line held
// - later hard resets keep power-on configuration
// - external soft accepted only while not resetting
module rsc_top #(
    parameter [`RSC_CNT_W-1:0] PINS_LO_CYC = `RSC_PINS_LO_CYC,
    parameter [`RSC_CNT_W-1:0] PINS_HI_CYC = `RSC_PINS_HI_CYC,
    parameter [`RSC_CNT_W-1:0] I2C_B0_CYC = `RSC_I2C_B0_CYC,
    parameter [`RSC_CNT_W-1:0] I2C_B1_CYC = `RSC_I2C_B1_CYC,
    parameter [`RSC_CNT_W-1:0] I2C_B2_CYC = `RSC_I2C_B2_CYC,
    parameter [`RSC_CNT_W-1:0] I2C_B3_CYC = `RSC_I2C_B3_CYC,
    parameter [`RSC_WORD_W-1:0] HARDCODED_WORD = 17'h00000
) (
    input wire clk_i,
    input wire reset_i,
    input wire power_on_reset_in_n_i,
    input wire hard_reset_line_n_i,
    output reg hard_reset_line_n_o,
    output reg hard_reset_line_oe_n_o,
    input wire soft_reset_line_n_i,
    output reg soft_reset_line_n_o,
    output reg soft_reset_line_oe_n_o,
    input wire [2:0] config_source_select_i,
    input wire [`RSC_WORD_W-1:0] config_word_pins_i,
    input wire [1:0] input_clock_range_pin_i,
    input wire boot_stop_pin_i,
    input wire wdog_hard_req_i,
    input wire sw_hard_req_i,
    input wire link_hard_req_i,
    input wire sw_soft_req_i,
    input wire tap_soft_req_i,
    input wire tap_boundary_i,
    input wire i2c_word_valid_i,
    input wire [`RSC_WORD_W-1:0] i2c_word_i,
    output reg pll_reset_o,
    output reg periph_reset_o,
    output reg core_reset_o,
    output reg full_reset_o,
    output reg partial_reset_o,
    output reg i2c_load_req_o,
    output reg [`RSC_WORD_W-1:0] reset_config_word_o,
    output reg [2:0] config_source_o,
    output reg [1:0] clock_range_o,
    output reg boot_stop_o,
    output reg config_valid_o,
    output reg [1:0] last_reset_class_o
);
    wire [`RSC_SYNC_W-1:0] pins_s;
    wire por_n_s;
    wire hard_n_s;
    wire soft_n_s;
    wire [2:0] src_s;
    wire [`RSC_WORD_W-1:0] word_s;
    wire [1:0] rng_s;
    wire stop_s;

    rsc_sync #(
        .WIDTH(`RSC_SYNC_W)
    ) u_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .d_i({power_on_reset_in_n_i, hard_reset_line_n_i, soft_reset_line_n_i, config_source_select_i,
              config_word_pins_i, input_clock_range_pin_i, boot_stop_pin_i}),
        .q_o(pins_s)
    );

    assign {por_n_s, hard_n_s, soft_n_s, src_s, word_s, rng_s, stop_s} = pins_s;

    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [1:0] cls_r;
    reg [1:0] cls_nxt;
    reg [`RSC_CNT_W-1:0] cnt_r;
    reg [`RSC_CNT_W-1:0] cnt_nxt;
    reg [`RSC_CNT_W-1:0] por_cnt;
    reg [`RSC_CNT_W-1:0] hard_cnt;

    // while we drive a line it reads low, so only these states may trust the pin
    wire ext_hard_ok = (state_r == `RSC_ST_IDLE) || (state_r == `RSC_ST_SOFT);
    wire int_hard_req = wdog_hard_req_i | sw_hard_req_i | link_hard_req_i;
    wire hard_req = int_hard_req | (~hard_n_s & ext_hard_ok);
    wire int_soft_req = sw_soft_req_i | tap_soft_req_i;
    wire soft_req = int_soft_req | (~soft_n_s & (state_r == `RSC_ST_IDLE));

    // release count chosen from the configuration being latched right now
    always @* begin
        if (src_s == `RSC_SRC_I2C) begin
            case (rng_s)
                `RSC_RNG_33_44: por_cnt = I2C_B0_CYC - 18'h1;
                `RSC_RNG_44_66: por_cnt = I2C_B1_CYC - 18'h1;
                `RSC_RNG_66_100: por_cnt = I2C_B2_CYC - 18'h1;
                default: por_cnt = I2C_B3_CYC - 18'h1;
            endcase
        end else begin
            por_cnt = rng_s[1] ? (PINS_HI_CYC - 18'h1) : (PINS_LO_CYC - 18'h1);
        end
        // later hard resets reuse the power-on clock range, no reload
        hard_cnt = clock_range_o[1] ? (PINS_HI_CYC - 18'h1) : (PINS_LO_CYC - 18'h1);
    end

    always @* begin
        state_nxt = state_r;
        cls_nxt = cls_r;
        cnt_nxt = cnt_r;
        if (!por_n_s) begin
            state_nxt = `RSC_ST_POR;
            cls_nxt = `RSC_CLS_POR;
        end else begin
            case (state_r)
                `RSC_ST_POR: begin
                    state_nxt = `RSC_ST_HARD;
                    cnt_nxt = por_cnt;
                end
                `RSC_ST_HARD: begin
                    // any hard or soft request here is absorbed
                    if (cnt_r == 18'h0) begin
                        state_nxt = `RSC_ST_TAIL;
                        cnt_nxt = `RSC_TAIL_CYC - 18'h1;
                    end else begin
                        cnt_nxt = cnt_r - 18'h1;
                    end
                end
                `RSC_ST_TAIL: begin
                    if (int_hard_req) begin
                        state_nxt = `RSC_ST_HARD;
                        cls_nxt = `RSC_CLS_HARD;
                        cnt_nxt = hard_cnt;
                    end else if (cnt_r == 18'h0) begin
                        state_nxt = `RSC_ST_QUIET;
                        cnt_nxt = `RSC_QUIET_CYC - 18'h1;
                    end else begin
                        cnt_nxt = cnt_r - 18'h1;
                    end
                end
                `RSC_ST_SOFT: begin
                    if (hard_req) begin
                        state_nxt = `RSC_ST_HARD;
                        cls_nxt = `RSC_CLS_HARD;
                        cnt_nxt = hard_cnt;
                    end else if (cnt_r == 18'h0) begin
                        state_nxt = `RSC_ST_QUIET;
                        cnt_nxt = `RSC_QUIET_CYC - 18'h1;
                    end else begin
                        cnt_nxt = cnt_r - 18'h1;
                    end
                end
                `RSC_ST_QUIET: begin
                    // pins still read the old low level through the synchroniser
                    if (int_hard_req) begin
                        state_nxt = `RSC_ST_HARD;
                        cls_nxt = `RSC_CLS_HARD;
                        cnt_nxt = hard_cnt;
                    end else if (int_soft_req) begin
                        state_nxt = `RSC_ST_SOFT;
                        cls_nxt = `RSC_CLS_SOFT;
                        cnt_nxt = `RSC_SOFT_HOLD_CYC - 18'h1;
                    end else if (cnt_r == 18'h0) begin
                        state_nxt = `RSC_ST_IDLE;
                    end else begin
                        cnt_nxt = cnt_r - 18'h1;
                    end
                end
                `RSC_ST_IDLE: begin
                    if (hard_req) begin
                        state_nxt = `RSC_ST_HARD;
                        cls_nxt = `RSC_CLS_HARD;
                        cnt_nxt = hard_cnt;
                    end else if (soft_req) begin
                        state_nxt = `RSC_ST_SOFT;
                        cls_nxt = `RSC_CLS_SOFT;
                        cnt_nxt = `RSC_SOFT_HOLD_CYC - 18'h1;
                    end
                end
                default: begin
                    state_nxt = `RSC_ST_POR;
                    cls_nxt = `RSC_CLS_POR;
                end
            endcase
        end
    end

    wire drv_hard = (state_nxt == `RSC_ST_POR) || (state_nxt == `RSC_ST_HARD);
    wire drv_soft = drv_hard || (state_nxt == `RSC_ST_TAIL) || (state_nxt == `RSC_ST_SOFT);
    wire full_nxt = drv_hard || (state_nxt == `RSC_ST_TAIL);
    wire i2c_nxt = (state_nxt == `RSC_ST_HARD) && (cls_nxt == `RSC_CLS_POR) && (config_source_o == `RSC_SRC_I2C);

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_r <= `RSC_ST_POR;
            cls_r <= `RSC_CLS_POR;
            cnt_r <= 18'h0;
            hard_reset_line_n_o <= 1'b0;
            hard_reset_line_oe_n_o <= 1'b0;
            soft_reset_line_n_o <= 1'b0;
            soft_reset_line_oe_n_o <= 1'b0;
            pll_reset_o <= 1'b1;
            periph_reset_o <= 1'b1;
            core_reset_o <= 1'b1;
            full_reset_o <= 1'b1;
            partial_reset_o <= 1'b1;
            i2c_load_req_o <= 1'b0;
            reset_config_word_o <= 17'h00000;
            config_source_o <= 3'h0;
            clock_range_o <= 2'h0;
            boot_stop_o <= 1'b0;
            config_valid_o <= 1'b0;
            last_reset_class_o <= `RSC_CLS_NONE;
        end else begin
            state_r <= state_nxt;
            cls_r <= cls_nxt;
            cnt_r <= cnt_nxt;
            // open drain: level is always low, the enable decides
            hard_reset_line_n_o <= 1'b0;
            hard_reset_line_oe_n_o <= ~drv_hard;
            soft_reset_line_n_o <= 1'b0;
            soft_reset_line_oe_n_o <= ~drv_soft;
            pll_reset_o <= (state_nxt == `RSC_ST_POR);
            periph_reset_o <= (state_nxt != `RSC_ST_IDLE && state_nxt != `RSC_ST_QUIET) || tap_boundary_i;
            core_reset_o <= (state_nxt != `RSC_ST_IDLE && state_nxt != `RSC_ST_QUIET) || tap_boundary_i;
            full_reset_o <= full_nxt;
            partial_reset_o <= drv_soft || tap_boundary_i;
            i2c_load_req_o <= i2c_nxt;
            if (state_nxt != `RSC_ST_IDLE && state_nxt != `RSC_ST_QUIET) begin
                last_reset_class_o <= cls_nxt;
            end
            if (state_r == `RSC_ST_POR) begin
                // latched every cycle of the power-on hold; last value wins
                config_source_o <= src_s;
                clock_range_o <= rng_s;
                boot_stop_o <= (src_s == `RSC_SRC_I2C) ? stop_s : 1'b0;
                config_valid_o <= 1'b0;
                if (src_s == `RSC_SRC_PINS) begin
                    reset_config_word_o <= word_s;
                end else if (src_s == `RSC_SRC_I2C) begin
                    reset_config_word_o <= 17'h00000;
                end else begin
                    reset_config_word_o <= HARDCODED_WORD;
                end
            end else if (i2c_load_req_o && i2c_word_valid_i) begin
                reset_config_word_o <= i2c_word_i;
            end
            if (state_r == `RSC_ST_HARD && state_nxt == `RSC_ST_TAIL && cls_r == `RSC_CLS_POR) begin
                config_valid_o <= 1'b1;
            end
        end
    end
endmodule // rsc_top

// >>> tb/rsc_board.sv
// rsc_board.sv: board model with pulled-up open-drain reset lines and a config eeprom
// assumes the eeprom answers a load request after a fixed delay
`timescale 1ns/1ps
module rsc_board #(
    parameter DLY = 20
) (
    input wire clk_i,
    input wire hard_oe_n_i,
    input wire soft_oe_n_i,
    input wire ext_hard_i,
    input wire ext_soft_i,
    input wire load_req_i,
    input wire [16:0] eep_word_i,
    output wire hard_line_n_o,
    output wire soft_line_n_o,
    output reg word_valid_o = 1'h0,
    output reg [16:0] word_o = 17'h00000
);
    reg [7:0] cnt_r = 8'h00;
    // pull-up wins unless a party pulls the line low
    assign hard_line_n_o = hard_oe_n_i & ~ext_hard_i;
    assign soft_line_n_o = soft_oe_n_i & ~ext_soft_i;
    always @(posedge clk_i) begin
        cnt_r <= load_req_i ? cnt_r + 8'h01 : 8'h00;
        word_valid_o <= load_req_i && cnt_r == DLY;
        // data only means something with the strobe, so it wanders otherwise
        word_o <= (load_req_i && cnt_r == DLY) ? eep_word_i : ~word_o;
    end
endmodule // rsc_board

// >>> tb/rsc_props.sv
// rsc_props.sv: port assertions for the chip reset sequencer
// assumes binding into rsc_top with its count parameters passed down
`timescale 1ns/1ps
`include "rsc_defs.vh"
module rsc_props #(
    parameter [17:0] PINS_LO_CYC = 18'h0, parameter [17:0] PINS_HI_CYC = 18'h0,
    parameter [17:0] I2C_B0_CYC = 18'h0, parameter [17:0] I2C_B1_CYC = 18'h0,
    parameter [17:0] I2C_B2_CYC = 18'h0, parameter [17:0] I2C_B3_CYC = 18'h0
) (
    input wire clk_i,
    input wire reset_i,
    input wire hard_reset_line_n_i,
    input wire hard_reset_line_oe_n_o,
    input wire soft_reset_line_oe_n_o,
    input wire wdog_hard_req_i,
    input wire sw_hard_req_i,
    input wire link_hard_req_i,
    input wire sw_soft_req_i,
    input wire tap_boundary_i,
    input wire pll_reset_o,
    input wire periph_reset_o,
    input wire core_reset_o,
    input wire full_reset_o,
    input wire partial_reset_o,
    input wire i2c_load_req_o,
    input wire [16:0] reset_config_word_o,
    input wire [2:0] config_source_o,
    input wire [1:0] clock_range_o,
    input wire config_valid_o,
    input wire [1:0] last_reset_class_o
);
    wire ho = hard_reset_line_oe_n_o;
    wire so = soft_reset_line_oe_n_o;
    wire hreq = wdog_hard_req_i | sw_hard_req_i | link_hard_req_i;
    wire [1:0] cr = clock_range_o;
    wire [17:0] i2c_n = cr[1] ? (cr[0] ? I2C_B3_CYC : I2C_B2_CYC) : (cr[0] ? I2C_B1_CYC : I2C_B0_CYC);
    wire [17:0] exp_n = (config_source_o == `RSC_SRC_I2C) ? i2c_n : (cr[1] ? PINS_HI_CYC : PINS_LO_CYC);
    reg [4:0] scnt_r;
    reg [17:0] hcnt_r;
    // counts soft-only cycles and hard cycles since the power-on hold ended
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            scnt_r <= 5'h00;
            hcnt_r <= 18'h00000;
        end else begin
            scnt_r <= (!so && ho) ? scnt_r + 5'h01 : 5'h00;
            hcnt_r <= (!ho && !pll_reset_o) ? hcnt_r + 18'h00001 : 18'h00000;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    a_soft_under_hard: assert property (!ho |-> !so && full_reset_o)
        else $error("soft line or full reset free under hard line");
    a_soft_blocks: assert property (!so |-> periph_reset_o && core_reset_o && partial_reset_o)
        else $error("block resets low while soft line driven");
    a_pll_hold: assert property (pll_reset_o |-> !ho && !so)
        else $error("pll reset without both lines driven");
    a_tap_blocks: assert property (tap_boundary_i |=> periph_reset_o && core_reset_o && partial_reset_o)
        else $error("boundary command did not reset blocks");
    a_cfg_kept: assert property ($past(config_valid_o) && !pll_reset_o |->
        $stable(reset_config_word_o) && $stable(config_source_o) && $stable(clock_range_o))
        else $error("configuration changed outside power-on hold");
    a_hard_take: assert property (config_valid_o && hreq |=> !ho)
        else $error("internal hard request not taken");
    a_soft_take: assert property (config_valid_o && ho && so && hard_reset_line_n_i && !hreq && sw_soft_req_i
        |=> ho && !so)
        else $error("soft request not taken as soft only");
    a_tail_len: assert property ($rose(so) |-> scnt_r == 5'h10)
        else $error("soft line released at wrong count");
    a_por_count: assert property ($rose(ho) && last_reset_class_o == `RSC_CLS_POR |-> hcnt_r == exp_n)
        else $error("power-on hard release at wrong count");
    // eeprom loading belongs only to the hard count of a power-on sequence with the eeprom source
    a_load_window: assert property (i2c_load_req_o |->
        !ho && !pll_reset_o && config_source_o == `RSC_SRC_I2C && last_reset_class_o == `RSC_CLS_POR)
        else $error("eeprom load requested outside power-on hard count");
endmodule // rsc_props
bind rsc_top rsc_props #(.PINS_LO_CYC(PINS_LO_CYC), .PINS_HI_CYC(PINS_HI_CYC), .I2C_B0_CYC(I2C_B0_CYC),
    .I2C_B1_CYC(I2C_B1_CYC), .I2C_B2_CYC(I2C_B2_CYC), .I2C_B3_CYC(I2C_B3_CYC)) u_props (.clk_i, .reset_i,
    .hard_reset_line_n_i, .hard_reset_line_oe_n_o, .soft_reset_line_oe_n_o, .wdog_hard_req_i, .sw_hard_req_i,
    .link_hard_req_i, .sw_soft_req_i, .tap_boundary_i, .pll_reset_o, .periph_reset_o, .core_reset_o,
    .full_reset_o, .partial_reset_o, .i2c_load_req_o, .reset_config_word_o, .config_source_o, .clock_range_o,
    .config_valid_o, .last_reset_class_o);

// >>> tb/rsc_top_tb.sv
// rsc_top_tb.sv: directed bench for the chip reset sequencer
// assumes rsc_board for lines and eeprom, rsc_props bound to the design
`timescale 1ns/1ps
`include "rsc_defs.vh"
module rsc_top_tb;
    localparam [16:0] HCW = 17'h0a5a5;
    // shortened release counts keep the run small; the checker takes its expectations from them as well
    localparam [17:0] LO_CYC = 18'h28, HI_CYC = 18'h3c;
    localparam [17:0] B0_CYC = 18'h32, B1_CYC = 18'h3c, B2_CYC = 18'h46, B3_CYC = 18'h50;
    reg clk = 1'h0, rst = 1'h1, por_n = 1'h0, bstop = 1'h0, tapb = 1'h0, ext_h = 1'h0, ext_s = 1'h0;
    reg [2:0] src = 3'h0;
    reg [1:0] rng = 2'h0;
    reg [16:0] pins = 17'h00000, eep = 17'h00000, ew;
    reg [4:0] rq = 5'h00;
    wire hl, sl, wv, ho, so, lreq, pll, per, cor, ful, par, bso, cv, hlo, slo;
    wire [16:0] ww, cw;
    wire [2:0] cs;
    wire [1:0] cr, lc;
    integer error_cnt = 0, total_checks = 0, n;
    always #5 clk = ~clk;
    rsc_top #(.PINS_LO_CYC(LO_CYC), .PINS_HI_CYC(HI_CYC), .I2C_B0_CYC(B0_CYC), .I2C_B1_CYC(B1_CYC),
        .I2C_B2_CYC(B2_CYC), .I2C_B3_CYC(B3_CYC), .HARDCODED_WORD(HCW)) u_dut (.clk_i(clk), .reset_i(rst),
        .power_on_reset_in_n_i(por_n), .hard_reset_line_n_i(hl), .hard_reset_line_n_o(hlo),
        .hard_reset_line_oe_n_o(ho), .soft_reset_line_n_i(sl), .soft_reset_line_n_o(slo),
        .soft_reset_line_oe_n_o(so),
        .config_source_select_i(src), .config_word_pins_i(pins), .input_clock_range_pin_i(rng),
        .boot_stop_pin_i(bstop), .wdog_hard_req_i(rq[0]), .sw_hard_req_i(rq[1]), .link_hard_req_i(rq[2]),
        .sw_soft_req_i(rq[3]), .tap_soft_req_i(rq[4]), .tap_boundary_i(tapb), .i2c_word_valid_i(wv),
        .i2c_word_i(ww), .pll_reset_o(pll), .periph_reset_o(per), .core_reset_o(cor), .full_reset_o(ful),
        .partial_reset_o(par), .i2c_load_req_o(lreq), .reset_config_word_o(cw), .config_source_o(cs),
        .clock_range_o(cr), .boot_stop_o(bso), .config_valid_o(cv), .last_reset_class_o(lc));
    rsc_board u_board (.clk_i(clk), .hard_oe_n_i(ho), .soft_oe_n_i(so), .ext_hard_i(ext_h), .ext_soft_i(ext_s),
        .load_req_i(lreq), .eep_word_i(eep), .hard_line_n_o(hl), .soft_line_n_o(sl), .word_valid_o(wv), .word_o(ww));
    task step(input integer c);
        begin
            repeat (c) @(posedge clk);
            #1;
        end
    endtask
    task check(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", total_checks, error_cnt);
            if (error_cnt == 0 && total_checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // bounded wait for both lines free, then the quiet window
    task wait_idle;
        integer k;
        begin
            for (k = 0; k < 3000 && !(ho === 1'h1 && so === 1'h1 && cv === 1'h1); k = k + 1)
                step(1);
            if (k >= 3000) begin
                error_cnt = error_cnt + 1;
                $display("MISMATCH at %0t: sequence hung", $time);
                final_report;
            end
            step(6);
        end
    endtask
    // internal requests for one cycle, external lines low for five, until the sequence has begun
    task pulse(input [4:0] v, input h, input s);
        begin
            rq = v;
            ext_h = h;
            ext_s = s;
            step(1);
            rq = 5'h00;
            step(4);
            ext_h = 1'h0;
            ext_s = 1'h0;
        end
    endtask
    initial begin
        step(5);
        rst = 1'h0;
        for (n = 0; n < 7; n = n + 1) begin
            src = (n == 1) ? 3'h5 : (n > 1 && n < 6) ? `RSC_SRC_I2C : `RSC_SRC_PINS;
            rng = (n == 1) ? 2'h2 : (n == 6) ? 2'h3 : (n < 2) ? 2'h0 : n - 2;
            pins = 17'h1c3e1 ^ n;
            eep = 17'h05a5a + n;
            bstop = n[0];
            ew = (src == `RSC_SRC_PINS) ? pins : (src == `RSC_SRC_I2C) ? eep : HCW;
            por_n = 1'h0;
            step(40);
            por_n = 1'h1;
            wait_idle;
            check(cw, ew);
            check({cs, cr}, {src, rng});
            check({cv, pll, lc}, {1'h1, 1'h0, `RSC_CLS_POR});
            // boot stop is kept only for eeprom loading; the load request must have dropped with the hard line
            check({bso, lreq}, {(src == `RSC_SRC_I2C) & bstop, 1'h0});
            check({hlo, slo}, 2'h0);
        end
        $display("test power-on sources done");
        pins = 17'h00000;
        for (n = 0; n < 4; n = n + 1) begin
            pulse((n < 3) ? 5'h01 << n : 5'h00, n == 3, 1'h0);
            check({ho, so, ful}, 3'h1);
            pulse(5'h08, 1'h0, 1'h1);
            wait_idle;
            step(20);
            check({ho, so, lc}, {2'h3, `RSC_CLS_HARD});
            check({cw, cr}, {17'h1c3e7, 2'h3});
        end
        $display("test hard sources done");
        for (n = 0; n < 3; n = n + 1) begin
            pulse((n < 2) ? 5'h08 << n : 5'h00, 1'h0, n == 2);
            check({ho, so, ful, par}, 4'h9);
            wait_idle;
            check(lc, `RSC_CLS_SOFT);
        end
        rq = 5'h08;
        step(1);
        pulse(5'h04, 1'h0, 1'h0);
        check({ho, ful}, 2'h1);
        wait_idle;
        check(lc, `RSC_CLS_HARD);
        $display("test soft and restart done");
        tapb = 1'h1;
        step(2);
        check({per, cor, par, ho, so}, 5'h1f);
        tapb = 1'h0;
        step(2);
        check({per, cor, par}, 3'h0);
        $display("test boundary done");
        final_report;
    end
endmodule // rsc_top_tb
